/* File: include/mcd_defines.vh */
// Constants for the multiplexed channel controller
`ifndef MCD_DEFINES_VH
`define MCD_DEFINES_VH

// ********************************
// Timing
// ********************************
`define MCD_CLK_NS 20
`define MCD_CYC_NS 1700
`define MCD_CYC_CLKS ((`MCD_CYC_NS + `MCD_CLK_NS - 1) / `MCD_CLK_NS)
`define MCD_EOR_NS 1000
`define MCD_EOR_CLKS ((`MCD_EOR_NS + `MCD_CLK_NS - 1) / `MCD_CLK_NS)
`define MCD_T1_CLKS 21
`define MCD_T3_CLKS 63

// ********************************
// Register map
// ********************************
`define MCD_CTRL_OFS 8'h00
`define MCD_STAT_OFS 8'h04
`define MCD_BASE_OFS 8'h08
`define MCD_CTRL_RST 32'h0000_ff01
`define MCD_BASE_RST 14'h0020
`define MCD_CTRL_EN_BIT 0
`define MCD_CTRL_MASK_LO 8

// ********************************
// Channel start word layout
// ********************************
`define MCD_WORD_BLK_BIT 15
`define MCD_WORD_DIR_BIT 14
`define MCD_ADDR_W 14
`define MCD_DATA_W 16

`endif

/* File: rtl/mcd_sync2.v */
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module mcd_sync2 #(
  parameter W = 8
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Pins and synchronised levels
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // mcd_sync2

/* File: rtl/mcd_apb_regs.v */
// APB register slave of the multiplexed channel controller
`timescale 1ns/1ps
`include "mcd_defines.vh"
module mcd_apb_regs (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Block side
  input wire [15:0] status_i,
  output wire ctrl_en_o,
  output wire [7:0] chan_mask_o,
  output wire [13:0] tbl_base_o
);
  reg [31:0] ctrl_ff;
  reg [13:0] base_ff;
  reg err_ff;
  wire setup;
  wire hit;

  assign setup = psel_i & ~penable_i;
  assign hit = (paddr_i == `MCD_CTRL_OFS) | (paddr_i == `MCD_STAT_OFS) | (paddr_i == `MCD_BASE_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = err_ff & psel_i & penable_i;
  assign ctrl_en_o = ctrl_ff[`MCD_CTRL_EN_BIT];
  assign chan_mask_o = ctrl_ff[`MCD_CTRL_MASK_LO+7:`MCD_CTRL_MASK_LO];
  assign tbl_base_o = base_ff;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `MCD_CTRL_RST;
      base_ff <= `MCD_BASE_RST;
      prdata_o <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      if (setup) begin
        err_ff <= ~hit;
        case (paddr_i)
          `MCD_CTRL_OFS: prdata_o <= ctrl_ff;
          `MCD_STAT_OFS: prdata_o <= {16'h0000, status_i};
          `MCD_BASE_OFS: prdata_o <= {18'h0_0000, base_ff};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
      if (psel_i & penable_i & pwrite_i) begin
        if (paddr_i == `MCD_CTRL_OFS) begin
          ctrl_ff <= {16'h0000, pwdata_i[15:8], 7'h00, pwdata_i[0]};
        end
        if (paddr_i == `MCD_BASE_OFS) begin
          base_ff <= pwdata_i[13:0];
        end
      end
    end
  end
endmodule // mcd_apb_regs

/* File: rtl/mcd_channel_ctrl.v */
// Multiplexed channel controller: sync, priority, four-cycle transfer
//
// Functional notes
// - On a channel request, halt program at instruction end and hold processor.
// - While holding, own memory and processor datapath for data and pointers.
// - Transfer is four 1.7 us cycles: update, end fetch, transfer, compare-sync.
// - Program counter and accumulator untouched; resume fetch unless new request.
// - Channel mode bits come from the stored start address word.
// - Time-sharing releases after empty sync; block mode repeats sync cycles.
// - Block mode lasts until end of range or device stop; stop releases.
// - A sync cycle runs with every processor cycle, sampling all requests.
// - Among active requests the highest priority channel is selected.
// - Accept only in last instruction cycle; otherwise drop and re-evaluate.
// - On acceptance force channel location into memory address register.
// - Update cycle asserts channel address select and increments start address.
// - End fetch reads end address; transfer cycle moves one word on bus.
// - Compare-sync reruns priority, compares addresses, pulses end of range.
// - After compare-sync, return to interrupted fetch, then passive sync.
// - End of range: select held one more microsecond, no request, release.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "mcd_defines.vh"
module mcd_channel_ctrl (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Processor timing and hold
  input wire cyc_start_i,
  input wire last_cycle_i,
  output reg hold_o,
  output reg mar_force_o,
  output reg [13:0] mar_addr_o,
  // Memory port
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [13:0] mem_addr_o,
  output reg [15:0] mem_wdata_o,
  input wire [15:0] mem_rdata_i,
  input wire mem_ack_i,
  // Device channel lines
  input wire [7:0] channel_request_i,
  input wire [7:0] device_stop_line_i,
  output reg [7:0] channel_address_select_o,
  output reg end_of_range_pulse_o,
  // Standard I/O bus
  input wire [15:0] in_bus_i,
  output reg [15:0] out_bus_o,
  output reg out_strobe_o,
  output reg ready_reset_o
);

  // ********************************
  // States and constants
  // ********************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_FETCH = 3'd1;
  localparam [2:0] ST_UPD = 3'd2;
  localparam [2:0] ST_END = 3'd3;
  localparam [2:0] ST_XFER = 3'd4;
  localparam [2:0] ST_CMP = 3'd5;
  localparam [2:0] ST_EOR = 3'd6;
  localparam [2:0] ST_BLK = 3'd7;
  localparam integer CYC_LAST_I = `MCD_CYC_CLKS - 1;
  localparam integer EOR_LAST_I = `MCD_EOR_CLKS - 1;
  localparam integer T3_CNT_I = `MCD_T3_CLKS;
  localparam integer T3_NEXT_I = `MCD_T3_CLKS + 1;
  localparam [6:0] CYC_LAST = CYC_LAST_I[6:0];
  localparam [6:0] EOR_LAST = EOR_LAST_I[6:0];
  localparam [6:0] T3_CNT = T3_CNT_I[6:0];
  localparam [6:0] T3_NEXT = T3_NEXT_I[6:0];

  // ********************************
  // Functions
  // ********************************
  function [3:0] prio_pick;
    input [7:0] req;
    integer i;
    begin
      prio_pick = 4'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (req[i]) begin
          prio_pick = {1'b1, i[2:0]};
        end
      end
    end
  endfunction

  function [7:0] one_hot;
    input [2:0] idx;
    begin
      one_hot = 8'h01 << idx;
    end
  endfunction

  function [13:0] tbl_addr;
    input [13:0] base;
    input [2:0] idx;
    input odd;
    begin
      tbl_addr = base + {10'h000, idx, odd};
    end
  endfunction

  // ********************************
  // Registers and wires
  // ********************************
  reg [2:0] st_ff, nxt_st;
  reg [6:0] cnt_ff, nxt_cnt;
  reg [2:0] ch_ff, nxt_ch;
  reg [13:0] ptr_ff, nxt_ptr;
  reg [13:0] end_ff, nxt_end;
  reg [15:0] data_ff, nxt_data;
  reg blkw_ff, nxt_blkw;
  reg dir_ff, nxt_dir;
  reg ackd_ff, nxt_ackd;
  reg [7:0] blk_ff, nxt_blk;
  reg guard_ff, nxt_guard;
  reg nxt_hold, nxt_mar_force, nxt_mem_req, nxt_mem_we;
  reg [13:0] nxt_mar_addr, nxt_mem_addr;
  reg [15:0] nxt_mem_wdata, nxt_out_bus;
  reg [7:0] nxt_sel;
  reg nxt_eor, nxt_strobe, nxt_rrl;
  reg [3:0] pick;
  reg cyc_end;
  wire [7:0] req_s;
  wire [7:0] stop_s;
  wire [15:0] in_s;
  wire ctrl_en;
  wire [7:0] chan_mask;
  wire [13:0] tbl_base;
  wire [7:0] req_eff;

  // ********************************
  // Pin synchronisers and registers
  // ********************************
  mcd_sync2 #(.W(8)) u_req_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(channel_request_i),
    .sync_o(req_s)
  );

  mcd_sync2 #(.W(8)) u_stop_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(device_stop_line_i),
    .sync_o(stop_s)
  );

  mcd_sync2 #(.W(16)) u_in_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(in_bus_i),
    .sync_o(in_s)
  );

  mcd_apb_regs u_regs (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .status_i({blk_ff, hold_o, st_ff, guard_ff, ch_ff}),
    .ctrl_en_o(ctrl_en),
    .chan_mask_o(chan_mask),
    .tbl_base_o(tbl_base)
  );

  assign req_eff = req_s & chan_mask & {8{ctrl_en}};

  // ********************************
  // Sequencer
  // ********************************
  always @* begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ch = ch_ff;
    nxt_ptr = ptr_ff;
    nxt_end = end_ff;
    nxt_data = data_ff;
    nxt_blkw = blkw_ff;
    nxt_dir = dir_ff;
    nxt_ackd = ackd_ff | mem_ack_i;
    nxt_blk = blk_ff & ~stop_s;
    nxt_guard = guard_ff;
    nxt_hold = hold_o;
    nxt_mar_force = 1'b0;
    nxt_mar_addr = mar_addr_o;
    nxt_mem_req = 1'b0;
    nxt_mem_we = mem_we_o;
    nxt_mem_addr = mem_addr_o;
    nxt_mem_wdata = mem_wdata_o;
    nxt_out_bus = out_bus_o;
    nxt_sel = channel_address_select_o;
    nxt_eor = 1'b0;
    nxt_strobe = 1'b0;
    nxt_rrl = 1'b0;
    pick = prio_pick(req_eff);
    cyc_end = (cnt_ff == CYC_LAST) && ackd_ff;
    if (st_ff != ST_IDLE && st_ff != ST_FETCH && st_ff != ST_EOR && cnt_ff != CYC_LAST) begin
      nxt_cnt = cnt_ff + 7'd1;
    end
    case (st_ff)
      ST_IDLE: begin
        if (cyc_start_i) begin
          if (pick[3] && last_cycle_i && !guard_ff) begin
            nxt_ch = pick[2:0];
            nxt_hold = 1'b1;
            nxt_mar_force = 1'b1;
            nxt_mar_addr = tbl_addr(tbl_base, pick[2:0], 1'b0);
            nxt_st = ST_FETCH;
          end else if (last_cycle_i) begin
            nxt_guard = 1'b0;
          end
        end
      end
      ST_FETCH: begin
        if (mem_ack_i) begin
          nxt_ptr = mem_rdata_i[13:0] + 14'h0001;
          nxt_blkw = mem_rdata_i[`MCD_WORD_BLK_BIT];
          nxt_dir = mem_rdata_i[`MCD_WORD_DIR_BIT];
          if (mem_rdata_i[`MCD_WORD_BLK_BIT]) begin
            nxt_blk = nxt_blk | one_hot(ch_ff);
          end
          nxt_sel = one_hot(ch_ff);
          nxt_st = ST_UPD;
          nxt_cnt = 7'd0;
          nxt_ackd = 1'b0;
        end
      end
      ST_UPD: begin
        if (cnt_ff == 7'd0) begin
          nxt_mem_req = 1'b1;
          nxt_mem_we = 1'b1;
          nxt_mem_addr = tbl_addr(tbl_base, ch_ff, 1'b0);
          nxt_mem_wdata = {blkw_ff, dir_ff, ptr_ff};
        end
        if (cyc_end) begin
          nxt_st = ST_END;
          nxt_cnt = 7'd0;
          nxt_ackd = 1'b0;
        end
      end
      ST_END: begin
        if (cnt_ff == 7'd0) begin
          nxt_mem_req = 1'b1;
          nxt_mem_we = 1'b0;
          nxt_mem_addr = tbl_addr(tbl_base, ch_ff, 1'b1);
        end
        if (mem_ack_i && !ackd_ff) begin
          nxt_end = mem_rdata_i[13:0];
        end
        if (cyc_end) begin
          nxt_st = ST_XFER;
          nxt_cnt = 7'd0;
          nxt_ackd = 1'b0;
        end
      end
      ST_XFER: begin
        if (dir_ff) begin
          if (cnt_ff == 7'd0) begin
            nxt_mem_req = 1'b1;
            nxt_mem_we = 1'b0;
            nxt_mem_addr = ptr_ff;
          end
          if (mem_ack_i && !ackd_ff) begin
            nxt_out_bus = mem_rdata_i;
          end
          if (cnt_ff == T3_CNT) begin
            nxt_strobe = 1'b1;
            nxt_rrl = 1'b1;
          end
        end else begin
          if (cnt_ff == T3_CNT) begin
            nxt_data = in_s;
            nxt_rrl = 1'b1;
          end
          if (cnt_ff == T3_NEXT) begin
            nxt_mem_req = 1'b1;
            nxt_mem_we = 1'b1;
            nxt_mem_addr = ptr_ff;
            nxt_mem_wdata = data_ff;
          end
        end
        if (cyc_end) begin
          nxt_st = ST_CMP;
          nxt_cnt = 7'd0;
          nxt_ackd = 1'b1;
          nxt_out_bus = 16'h0000;
        end
      end
      ST_CMP: begin
        if (cyc_end) begin
          nxt_cnt = 7'd0;
          pick = prio_pick(req_eff & ~one_hot(ch_ff));
          if (ptr_ff == end_ff) begin
            nxt_blk = nxt_blk & ~one_hot(ch_ff);
            nxt_eor = 1'b1;
            nxt_guard = 1'b1;
            nxt_st = ST_EOR;
          end else if (pick[3]) begin
            nxt_ch = pick[2:0];
            nxt_sel = 8'h00;
            nxt_mar_force = 1'b1;
            nxt_mar_addr = tbl_addr(tbl_base, pick[2:0], 1'b0);
            nxt_st = ST_FETCH;
          end else if (|nxt_blk) begin
            nxt_sel = 8'h00;
            nxt_st = ST_BLK;
          end else begin
            nxt_sel = 8'h00;
            nxt_hold = 1'b0;
            nxt_st = ST_IDLE;
          end
        end
      end
      ST_EOR: begin
        nxt_eor = 1'b1;
        nxt_cnt = cnt_ff + 7'd1;
        if (cnt_ff == EOR_LAST) begin
          nxt_eor = 1'b0;
          nxt_sel = 8'h00;
          nxt_hold = 1'b0;
          nxt_cnt = 7'd0;
          nxt_st = ST_IDLE;
        end
      end
      ST_BLK: begin
        if (cyc_end) begin
          nxt_cnt = 7'd0;
          if (pick[3]) begin
            nxt_ch = pick[2:0];
            nxt_mar_force = 1'b1;
            nxt_mar_addr = tbl_addr(tbl_base, pick[2:0], 1'b0);
            nxt_st = ST_FETCH;
          end else if (nxt_blk == 8'h00) begin
            nxt_hold = 1'b0;
            nxt_st = ST_IDLE;
          end
        end else if (nxt_blk == 8'h00) begin
          nxt_hold = 1'b0;
          nxt_cnt = 7'd0;
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
        nxt_hold = 1'b0;
      end
    endcase
  end

  // ********************************
  // State registers
  // ********************************
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 7'd0;
      ch_ff <= 3'd0;
      ptr_ff <= 14'h0000;
      end_ff <= 14'h0000;
      data_ff <= 16'h0000;
      blkw_ff <= 1'b0;
      dir_ff <= 1'b0;
      ackd_ff <= 1'b0;
      blk_ff <= 8'h00;
      guard_ff <= 1'b0;
      hold_o <= 1'b0;
      mar_force_o <= 1'b0;
      mar_addr_o <= 14'h0000;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 14'h0000;
      mem_wdata_o <= 16'h0000;
      out_bus_o <= 16'h0000;
      channel_address_select_o <= 8'h00;
      end_of_range_pulse_o <= 1'b0;
      out_strobe_o <= 1'b0;
      ready_reset_o <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ch_ff <= nxt_ch;
      ptr_ff <= nxt_ptr;
      end_ff <= nxt_end;
      data_ff <= nxt_data;
      blkw_ff <= nxt_blkw;
      dir_ff <= nxt_dir;
      ackd_ff <= nxt_ackd;
      blk_ff <= nxt_blk;
      guard_ff <= nxt_guard;
      hold_o <= nxt_hold;
      mar_force_o <= nxt_mar_force;
      mar_addr_o <= nxt_mar_addr;
      mem_req_o <= nxt_mem_req;
      mem_we_o <= nxt_mem_we;
      mem_addr_o <= nxt_mem_addr;
      mem_wdata_o <= nxt_mem_wdata;
      out_bus_o <= nxt_out_bus;
      channel_address_select_o <= nxt_sel;
      end_of_range_pulse_o <= nxt_eor;
      out_strobe_o <= nxt_strobe;
      ready_reset_o <= nxt_rrl;
    end
  end
endmodule // mcd_channel_ctrl

/* File: tb/mcd_channel_ctrl_chk.sv */
// Assertion checker for the channel controller ports
`timescale 1ns/1ps
module mcd_channel_ctrl_chk (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Watched ports
  input wire cyc_start_i,
  input wire last_cycle_i,
  input wire hold_o,
  input wire mar_force_o,
  input wire [7:0] channel_address_select_o,
  input wire end_of_range_pulse_o,
  input wire out_strobe_o,
  input wire ready_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] sel_prev_ff;
  logic [9:0] sel_len_ff;
  logic [6:0] eor_len_ff;
  // ****
  // Run lengths
  // ****
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sel_prev_ff <= 8'h00;
      sel_len_ff <= 10'h000;
      eor_len_ff <= 7'h00;
    end else begin
      sel_prev_ff <= channel_address_select_o;
      sel_len_ff <= (|channel_address_select_o && channel_address_select_o == sel_prev_ff) ?
        sel_len_ff + 10'h001 : 10'h000;
      eor_len_ff <= end_of_range_pulse_o ? eor_len_ff + 7'h01 : 7'h00;
    end
  end
  sequence s_held;
    hold_o [*8];
  endsequence
  sequence s_quiet;
    !hold_o && channel_address_select_o == 8'h00;
  endsequence
  a_force_held: assert property (mar_force_o |-> hold_o ##1 s_held) else $error("force without hold");
  a_force_pulse: assert property (mar_force_o |=> !mar_force_o) else $error("force too long");
  a_hold_cause: assert property ($rose(hold_o) |-> $past(cyc_start_i) && $past(last_cycle_i))
    else $error("hold outside last cycle sync");
  a_sel_onehot: assert property ($onehot0(channel_address_select_o)) else $error("select not one-hot");
  a_sel_span: assert property ($fell(|channel_address_select_o) |-> sel_len_ff >= 10'h152)
    else $error("sequence too short");
  a_eor_len: assert property ($fell(end_of_range_pulse_o) |-> eor_len_ff == 7'h32) else $error("end pulse width");
  a_eor_release: assert property ($fell(end_of_range_pulse_o) |-> ##[0:2] s_quiet)
    else $error("no release after end");
  a_strobe_sel: assert property (out_strobe_o |-> hold_o && |channel_address_select_o)
    else $error("strobe outside transfer");
  a_rrl_strobe: assert property (out_strobe_o |-> ready_reset_o) else $error("strobe without ready reset");
endmodule // mcd_channel_ctrl_chk

bind mcd_channel_ctrl mcd_channel_ctrl_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cyc_start_i(cyc_start_i),
  .last_cycle_i(last_cycle_i), .hold_o(hold_o), .mar_force_o(mar_force_o),
  .channel_address_select_o(channel_address_select_o), .end_of_range_pulse_o(end_of_range_pulse_o),
  .out_strobe_o(out_strobe_o), .ready_reset_o(ready_reset_o));

/* File: tb/mcd_dev_model.sv */
// Device interface model for the eight channel lines
`timescale 1ns/1ps
module mcd_dev_model (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Bench control
  input wire [7:0] want_i,
  input wire [7:0] stop_i,
  input wire [15:0] din_i,
  input wire [7:0] mode_i,
  // Controller lines
  input wire [7:0] sel_i,
  input wire eor_i,
  output logic [7:0] req_o = 8'h00,
  output logic [7:0] stop_o = 8'h00,
  output logic [15:0] in_bus_o = 16'h0000,
  output logic [7:0] eor_seen_o = 8'h00
);
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      req_o <= 8'h00;
      stop_o <= 8'h00;
      in_bus_o <= 16'h0000;
      eor_seen_o <= 8'h00;
    end else begin
      req_o <= (req_o | want_i) & mode_i & ~sel_i;
      stop_o <= stop_i;
      in_bus_o <= (sel_i != 8'h00) ? din_i : ~in_bus_o;
      eor_seen_o <= eor_seen_o | (eor_i ? sel_i : 8'h00);
    end
  end
endmodule // mcd_dev_model

/* File: tb/multiplexed_channel_dma_tb.sv */
// Self-checking bench for the multiplexed channel controller
`timescale 1ns/1ps
module multiplexed_channel_dma_tb;
  logic ref_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, cyc_start_i = 0, last_cycle_i = 0;
  logic mem_ack_i = 0, lc = 1, e, pw, fire, eor_prev = 0;
  logic [7:0] paddr_i = 0, want = 0, stop = 0, sel_prev = 0;
  logic [31:0] pwdata_i = 0, r;
  logic [15:0] mem_rdata_i = 0, din = 0, pd;
  logic [15:0] mem [0:16383];
  wire pready_o, pslverr_o, hold_o, mar_force_o, mem_req_o, mem_we_o, end_of_range_pulse_o, out_strobe_o;
  wire ready_reset_o;
  wire [31:0] prdata_o;
  wire [13:0] mar_addr_o, mem_addr_o;
  wire [15:0] mem_wdata_o, out_bus_o, in_bus_i;
  wire [7:0] channel_request_i, device_stop_line_i, channel_address_select_o, eor_seen;
  int seed = 84, err_total = 0, comparisons = 0, cyc_cnt = 0, pend = 0, pa, cur = 0, eor_n = 0, base = 256, i, n, n1;
  int mp[8];
  int rrl_n = 0;
  logic [7:0] mode = 0;
  int sel_q[$];
  always #10 ref_clk_i = ~ref_clk_i;
  mcd_channel_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .cyc_start_i(cyc_start_i), .last_cycle_i(last_cycle_i), .hold_o(hold_o),
    .mar_force_o(mar_force_o), .mar_addr_o(mar_addr_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
    .channel_request_i(channel_request_i), .device_stop_line_i(device_stop_line_i),
    .channel_address_select_o(channel_address_select_o), .end_of_range_pulse_o(end_of_range_pulse_o),
    .in_bus_i(in_bus_i), .out_bus_o(out_bus_o), .out_strobe_o(out_strobe_o), .ready_reset_o(ready_reset_o));
  mcd_dev_model u_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .want_i(want), .stop_i(stop), .din_i(din),
    .mode_i(mode), .sel_i(channel_address_select_o), .eor_i(end_of_range_pulse_o), .req_o(channel_request_i),
    .stop_o(device_stop_line_i), .in_bus_o(in_bus_i), .eor_seen_o(eor_seen));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task tk(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    tk(1);
    penable_i <= 1;
    do tk(1); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    tk(1);
  endtask
  task tbl(input int ch, input logic blk, input logic dir, input int st, input int en);
    mem[base + 2 * ch] = {blk, dir, 14'(st - 1)};
    mem[base + 2 * ch + 1] = 16'(en);
    mp[ch] = st - 1;
  endtask
  task run(input logic [7:0] w);
    want <= w;
    tk(1);
    want <= 8'h00;
    n = 0;
    while (hold_o !== 1'b1 && n < 400) begin
      tk(1);
      n++;
    end
    n1 = n;
    while (hold_o !== 1'b0 && n < 4000) begin
      tk(1);
      n++;
    end
  endtask
  task summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****
  // Processor cycles, memory and monitor
  // ****
  always @(posedge ref_clk_i) begin
    cyc_cnt <= (rst_i || cyc_cnt == 84) ? 0 : cyc_cnt + 1;
    cyc_start_i <= !rst_i && cyc_cnt == 84;
    last_cycle_i <= lc;
    fire = !(mar_force_o === 1'b1 || mem_req_o === 1'b1) && pend == 1;
    if (fire && pw) mem[pa] = pd;
    mem_rdata_i <= fire ? mem[pa] : ~mem_rdata_i;
    mem_ack_i <= fire;
    if (mar_force_o === 1'b1 || mem_req_o === 1'b1) begin
      pa = mar_force_o ? mar_addr_o : mem_addr_o;
      pw = mem_req_o & mem_we_o;
      pd = mem_wdata_o;
      pend = 1 + ($random(seed) & 3);
    end else if (pend > 0) begin
      pend--;
    end
    if (channel_address_select_o != sel_prev && channel_address_select_o != 8'h00) begin
      for (int k = 0; k < 8; k++)
        if (channel_address_select_o[k]) cur = k;
      mp[cur] = mp[cur] + 1;
      sel_q.push_back(cur);
    end
    sel_prev = channel_address_select_o;
    if (out_strobe_o === 1'b1) chk(out_bus_o, mem[mp[cur]]);
    if (ready_reset_o === 1'b1) rrl_n++;
    if (end_of_range_pulse_o === 1'b1 && !eor_prev) eor_n++;
    eor_prev = end_of_range_pulse_o;
  end
  initial begin
    #1_000_000;
    err_total++;
    summarize();
  end
  initial begin
    for (i = 0; i < 16384; i++) mem[i] = 16'($random(seed));
    tk(20);
    rst_i <= 0;
    mode <= 8'hff;
    tk(1);
    apb(0, 8'h00, 0);
    chk(r, 32'h0000_ff01);
    apb(0, 8'h08, 0);
    chk(r, 32'h0000_0020);
    apb(0, 8'h04, 0);
    chk(r, 0);
    apb(0, 8'h0c, 0);
    chk(r, 0);
    chk(e, 1);
    apb(1, 8'h08, base);
    apb(0, 8'h08, 0);
    chk(r, base);
    for (i = 0; i < 8; i++) tbl(i, 0, 1, 1024 + 256 * i, 1100 + 256 * i);
    run(8'h08);
    chk(sel_q.pop_front(), 3);
    chk(mem[base + 6], {2'b01, 14'(mp[3])});
    chk(hold_o, 0);
    run(8'h24);
    chk(sel_q.pop_front(), 2);
    chk(sel_q.pop_front(), 5);
    tbl(1, 0, 0, 3000, 3100);
    din <= 16'($random(seed));
    run(8'h02);
    chk(sel_q.pop_front(), 1);
    chk(mem[mp[1]], din);
    chk(rrl_n, 4);
    tbl(6, 0, 1, 3500, 3500);
    run(8'h40);
    chk(sel_q.pop_front(), 6);
    chk(eor_n, 1);
    chk(eor_seen, 8'h40);
    run(8'h10);
    chk(n1 >= 80, 1);
    chk(sel_q.pop_front(), 4);
    lc <= 0;
    run(8'h80);
    chk(hold_o, 0);
    chk(sel_q.size(), 0);
    lc <= 1;
    run(8'h00);
    chk(sel_q.pop_front(), 7);
    apb(1, 8'h00, 32'h0000_f701);
    run(8'h08);
    chk(sel_q.size(), 0);
    apb(1, 8'h00, 32'h0000_ff01);
    run(8'h00);
    chk(sel_q.pop_front(), 3);
    tbl(0, 1, 1, 4000, 4100);
    run(8'h01);
    chk(hold_o, 1);
    chk(mem[base], {2'b11, 14'(mp[0])});
    stop <= 8'h01;
    tk(200);
    stop <= 8'h00;
    chk(hold_o, 0);
    want <= 8'h04;
    tk(1);
    want <= 8'h00;
    tk(150);
    rst_i <= 1;
    tk(2);
    chk(hold_o, 0);
    chk(channel_address_select_o, 0);
    rst_i <= 0;
    tk(200);
    chk(hold_o, 0);
    summarize();
  end
endmodule // multiplexed_channel_dma_tb
